// [rtl/febe_pkg.sv]
// Package for the shared floating-point error / pending break event pin.
// Assumes a single 200 MHz core clock and an active-low async reset.
package febe_pkg;
  localparam logic RST_PIN_N   = 1'b1;
  localparam logic RST_FLAG    = 1'b0;
  localparam logic ASSERTED_N  = 1'b0;
  typedef enum logic [1:0] {
    FEBE_ERR_MODE   = 2'b00,
    FEBE_STOP_IDLE  = 2'b01,
    FEBE_STOP_BREAK = 2'b10
  } febe_state_t;
endpackage

// [rtl/febe_err_detect.sv]
// Unmasked floating-point error detector.
// Assumes error and mask inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module febe_err_detect
  import febe_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic fp_error,
  input  wire logic fp_error_mask,
  input  wire logic fp_error_clear,
  output logic      unmasked_err
);
  logic err_q;

  // An unmasked error still being raised wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_q <= RST_FLAG;
    end else if (fp_error && !fp_error_mask) begin
      err_q <= 1'b1;
    end else if (fp_error_clear) begin
      err_q <= 1'b0;
    end
  end

  assign unmasked_err = err_q;
endmodule
`default_nettype wire

// [rtl/febe_pin.sv]
// Drives the shared active-low error / break event output pin.
// Assumes stop_clock_request_n and core events are synchronous to clk.
//
// Overview of operation
// - One shared pin, plus gated copies float_error_n and pending_break_n; pin meaning chosen by stop-clock request: error or break event.
// - Without stop-clock request, assert output for unmasked floating-point errors.
// - With stop-clock request, assert only for a pending break event.
// - Break event assertion holds until stop-clock request is released.
`timescale 1ns/1ps
`default_nettype none
module febe_pin
  import febe_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic stop_clock_request_n,
  input  wire logic fp_error,
  input  wire logic fp_error_mask,
  input  wire logic fp_error_clear,
  input  wire logic break_event,
  output logic      fp_error_break_event_n,
  output logic      float_error_n,
  output logic      pending_break_n
);
  febe_state_t state_q;
  febe_state_t state_d;
  logic        stop_req;
  logic        unmasked_err;
  logic        pin_q;
  logic        pin_d;

  assign stop_req = (stop_clock_request_n == ASSERTED_N);

  febe_err_detect u_err (
    .clk            (clk),
    .rstn           (rstn),
    .fp_error       (fp_error),
    .fp_error_mask  (fp_error_mask),
    .fp_error_clear (fp_error_clear),
    .unmasked_err   (unmasked_err)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      FEBE_ERR_MODE: begin
        if (stop_req) begin
          state_d = break_event ? FEBE_STOP_BREAK : FEBE_STOP_IDLE;
        end
      end
      FEBE_STOP_IDLE: begin
        if (!stop_req) begin
          state_d = FEBE_ERR_MODE;
        end else if (break_event) begin
          state_d = FEBE_STOP_BREAK;
        end
      end
      FEBE_STOP_BREAK: begin
        if (!stop_req) begin
          state_d = FEBE_ERR_MODE;
        end
      end
      default: begin
        state_d = FEBE_ERR_MODE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= FEBE_ERR_MODE;
    end else begin
      state_q <= state_d;
    end
  end

  always_comb begin
    if (state_d == FEBE_ERR_MODE) begin
      pin_d = !unmasked_err;
    end else begin
      pin_d = (state_d != FEBE_STOP_BREAK);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_q <= RST_PIN_N;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign fp_error_break_event_n = pin_q;
  assign float_error_n          = (state_q == FEBE_ERR_MODE) ? pin_q : 1'b1;
  assign pending_break_n        = (state_q == FEBE_STOP_BREAK) ? pin_q : 1'b1;
endmodule
`default_nettype wire

// [tb/febe_pin_properties.sv]
// Checker for the shared pin.
// Assumes one clock and rstn.
`timescale 1ns/1ps
`default_nettype none
module febe_pin_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic stop_clock_request_n,
  input wire logic fp_error,
  input wire logic fp_error_mask,
  input wire logic break_event,
  input wire logic fp_error_break_event_n
);
  wire logic s = stop_clock_request_n;
  wire logic p = fp_error_break_event_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence err_seen;
    s && fp_error && !fp_error_mask;
  endsequence
  a_err_shown: assert property (err_seen ##1 s |=> !p)
    else $error("error hidden");
  a_break_shown: assert property (!s && break_event |=> !p)
    else $error("break hidden");
  a_break_held: assert property (!s && !$past(s) && !p |=> !p)
    else $error("break dropped");
  a_stop_quiet: assert property (!s && !$past(s) && p && !break_event |=> p)
    else $error("stray assert");
endmodule
bind febe_pin febe_pin_properties febe_pin_properties_i (.*);
`default_nettype wire

// [tb/febe_ctrl_model.sv]
// Controller that owns the stop request.
// Assumes req comes between edges.
`timescale 1ns/1ps
`default_nettype none
module febe_ctrl_model (
  input  wire logic clk,
  input  wire logic pin_n,
  input  wire logic req,
  output var logic  stop_n
);
  initial stop_n = 1'h1;
  always @(posedge clk) begin
    if (stop_n) stop_n <= !req;
    else if (!pin_n && !req) stop_n <= 1'h1;
  end
endmodule
`default_nettype wire

// [tb/fp_error_break_event_pin_tb_top.sv]
// Bench for the shared pin.
// Assumes the controller model.
`timescale 1ns/1ps
`default_nettype none
module fp_error_break_event_pin_tb_top;
  import febe_pkg::*;
  logic clk = 0, rstn = 0, q = 0, e = 0, m = 0, c = 0, b = 0;
  logic sn, p, fe, pb;
  int   failures = 0, n_tests = 0;
  initial forever #2.5 clk = ~clk;
  febe_ctrl_model febe_ctrl_model_i (.clk(clk), .pin_n(p), .req(q),
    .stop_n(sn));
  febe_pin febe_pin_i (.clk(clk), .rstn(rstn), .stop_clock_request_n(sn),
    .fp_error(e), .fp_error_mask(m), .fp_error_clear(c), .break_event(b),
    .fp_error_break_event_n(p), .float_error_n(fe), .pending_break_n(pb));
  task automatic k(input logic a, input logic x);
    n_tests++;
    if (a !== x) begin
      failures++;
      $display("CHECK FAILED %0t %h %h", $time, a, x);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_err;
    m = 1; e = 1; w(1); e = 0; w(3);
    k(p, 1'h1);
    m = 0; e = 1; w(1); e = 0; w(2);
    k(p, ASSERTED_N);
    k(fe, ASSERTED_N);
    c = 1; w(1); c = 0; w(2);
    k(p, 1'h1);
    $display("t_err end");
  endtask
  task automatic t_brk;
    q = 1; w(2);
    k(p, 1'h1);
    b = 1; w(1); b = 0; w(3);
    k(pb, ASSERTED_N);
    q = 0; w(3);
    k(p, 1'h1);
    $display("t_brk end");
  endtask
  initial begin
    w(10); rstn = 1; w(1);
    t_err;
    t_brk;
    tally_and_finish;
  end
  initial begin
    #2000 failures++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
